// ### tb_top.sv
// Self-checking testbench of the queue scheduling block
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic [63:0] v; logic [63:0] m;} tqs_exp_s;
   logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, sched_valid, desc_ready, tx_valid, tx_ready;
   logic comp_ready, rel_valid, rel_ready, irq;
   logic sched_ready = 1'b0, desc_valid = 1'b0, comp_valid = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] dma_queue_req = 16'h0;
   logic [15:0][1:0] dma_queue_prio = '0;
   tqs_pkg::tqs_sched_s sched;
   tqs_pkg::tqs_desc_s desc = '0;
   tqs_pkg::tqs_tx_s tx;
   tqs_pkg::tqs_comp_s comp = '0;
   tqs_pkg::tqs_rel_s rel;
   int seed = 32'hd62bb5af;
   int n_mismatch = 0, n_tests = 0;
   tqs_exp_s q_rd[$], q_wr[$], q_tx[$], q_rel[$];

   tqs_sched_discard uut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .dma_queue_req,
      .dma_queue_prio, .sched_valid, .sched_ready, .sched, .desc_valid,
      .desc_ready, .desc, .tx_valid, .tx_ready, .tx, .comp_valid,
      .comp_ready, .comp, .rel_valid, .rel_ready, .rel, .irq);
   tqs_far_model far (.aclk, .aresetn, .slow, .tx_valid, .tx_ready,
      .rel_valid, .rel_ready);

   // ==========================================================
   // Clock
   initial forever #5 aclk = ~aclk;

   // ==========================================================
   // Compare, verdict
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("Compares %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic stall();
      n_mismatch++;
      summarize();
   endtask : stall
   task automatic pop(ref tqs_exp_s q[$], input logic [63:0] got);
      tqs_exp_s e;
      e = '{~got, '1};
      if (q.size() > 0) e = q.pop_front();
      chk(got & e.m, e.v & e.m);
   endtask : pop

   // Output watcher takes the oldest note per stream
   always @(posedge aclk) begin
      if (aresetn) begin
         if (s_axi_rvalid && s_axi_rready)
            pop(q_rd, {30'h0, s_axi_rresp, s_axi_rdata});
         if (s_axi_bvalid && s_axi_bready) pop(q_wr, {62'h0, s_axi_bresp});
         if (tx_valid && tx_ready) pop(q_tx, {27'h0, tx});
         if (rel_valid && rel_ready) pop(q_rel, {14'h0, rel});
      end
   end

   // ==========================================================
   // Bus and stream drivers
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = 2'h0);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      q_wr.push_back('{{62'h0, r}, '1});
      for (i = 0; i < 300; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (i == 300) stall();
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = 2'h0, input logic [63:0] m = '1);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      q_rd.push_back('{{30'h0, r, d}, m});
      for (i = 0; i < 300; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (i == 300) stall();
   endtask : rd
   function automatic logic [31:0] info_exp(int k, logic [31:0] w);
      for (int j = 0; j < 4; j++)
         info_exp[8*j +: 8] = (w[8*j +: 8] & 8'h39) |
            {5'h0, dma_queue_prio[4*k+j], 1'b0};
   endfunction : info_exp
   task automatic send_desc(input logic [3:0] q, input logic t11, pe,
                            input logic [15:0] len);
      tqs_pkg::tqs_desc_s d;
      int i;
      d = '{32'($random(seed)), q, t11, pe, len, 12'h010};
      if (pe) q_rel.push_back('{{14'h0, d.ptr, 14'h0505, 4'h1},
         '1});
      else if (t11 && len[15:4] > 12'h010) q_rel.push_back('{{14'h0,
         d.ptr, 14'h0606, 4'h1}, '1});
      else q_tx.push_back('{{27'h0, d.ptr, q[1:0], dma_queue_prio[q],
         q[0]}, '1});
      @(posedge aclk);
      desc <= d;
      desc_valid <= 1'b1;
      for (i = 0; i < 300; i++) begin
         @(posedge aclk);
         if (desc_ready) break;
      end
      desc_valid <= 1'b0;
      desc <= ~d;
      if (i == 300) stall();
   endtask : send_desc
   task automatic send_comp(input logic [4:0] f, input logic [7:0] rc,
                            input logic [13:0] eq, input logic [3:0] ec);
      tqs_pkg::tqs_comp_s c;
      int i;
      c = '{32'($random(seed)), 14'h0aaa, f[4], f[3], rc, f[2], f[1], f[0]};
      q_rel.push_back('{{14'h0, c.ptr, eq, ec}, '1});
      @(posedge aclk);
      comp <= c;
      comp_valid <= 1'b1;
      for (i = 0; i < 300; i++) begin
         @(posedge aclk);
         if (comp_ready) break;
      end
      comp_valid <= 1'b0;
      comp <= ~c;
      if (i == 300) stall();
   endtask : send_comp
   task automatic pick(input logic [3:0] qa, input logic [1:0] pa,
                       input logic [3:0] qb, input logic [1:0] pb);
      logic [3:0] w;
      int i;
      w = ({pb, qb[0]} > {pa, qa[0]}) ? qb : qa;
      @(posedge aclk);
      dma_queue_prio[qa] <= pa;
      dma_queue_prio[qb] <= pb;
      dma_queue_req <= 16'(1) << qa | 16'(1) << qb;
      sched_ready <= 1'b0;
      for (i = 0; i < 300; i++) begin
         @(posedge aclk);
         if (sched_valid) break;
      end
      chk(sched, {w, w[1:0], (w == qa) ? pa : pb, w[0]});
      dma_queue_req <= 16'h0;
      sched_ready <= 1'b1;
      repeat (3) @(posedge aclk);
      if (i == 300) stall();
   endtask : pick
   task automatic drain();
      int i;
      for (i = 0; i < 1000; i++) begin
         @(posedge aclk);
         if (q_tx.size() + q_rel.size() == 0) break;
      end
      if (i == 1000) stall();
   endtask : drain

   // ==========================================================
   // Main sequence
   initial begin
      for (int q = 0; q < 16; q++) dma_queue_prio[q] = 2'(q % 3);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h10, 32'h0);
      rd(8'h1c, 32'h3);
      wr(8'h40, '1, 2'h2);
      rd(8'h40, 32'h0, 2'h2, 64'h3_0000_0000);
      for (int k = 0; k < 4; k++) begin
         wr(8'(4 * k), '1);
         rd(8'(4 * k), info_exp(k, '1));
         wr(8'(4 * k), 32'h39201900);
         rd(8'(4 * k), info_exp(k, 32'h39201900));
      end
      wr(8'h10, '1);
      rd(8'h10, 32'h3fff3fff);
      wr(8'h10, 32'h01010202);
      wr(8'h14, 32'h03030404);
      wr(8'h18, 32'h05050606);
      wr(8'h1c, 32'h5);
      slow <= 1'b1;
      send_desc(4'h5, 1'b1, 1'b0, 16'h010f);
      send_desc(4'h6, 1'b1, 1'b0, 16'h0110);
      send_desc(4'h7, 1'b1, 1'b1, 16'h0110);
      send_desc(4'h9, 1'b0, 1'b1, 16'h0000);
      send_desc(4'ha, 1'b0, 1'b0, 16'hffff);
      send_comp(5'b10000, 8'h0, 14'h0101, 4'h1);
      send_comp(5'b01000, 8'h0, 14'h0202, 4'h1);
      send_comp(5'b00000, 8'h6, 14'h0303, 4'h1);
      send_comp(5'b00000, 8'h5, 14'h0aaa, 4'h0);
      send_comp(5'b00100, 8'h0, 14'h0404, 4'h1);
      send_comp(5'b00011, 8'h0, 14'h0aaa, 4'h1);
      send_comp(5'b00010, 8'h0, 14'h0aaa, 4'h0);
      send_comp(5'b11000, 8'h0, 14'h0101, 4'h1);
      drain();
      slow <= 1'b0;
      rd(8'h20, 32'h3f);
      chk(irq, 1'b0);
      wr(8'h28, 32'h4);
      @(posedge aclk);
      chk(irq, 1'b1);
      wr(8'h24, 32'h4);
      @(posedge aclk);
      chk(irq, 1'b0);
      rd(8'h20, 32'h3b);
      rd(8'h24, 32'h0);
      wr(8'h24, 32'h3f);
      rd(8'h20, 32'h0);
      wr(8'h28, 32'h8);
      send_comp(5'b00100, 8'h0, 14'h0404, 4'h1);
      drain();
      chk(irq, 1'b1);
      wr(8'h24, 32'h8);
      pick(4'h6, 2'h1, 4'h7, 2'h1);
      pick(4'h8, 2'h2, 4'hd, 2'h1);
      pick(4'ha, 2'h0, 4'he, 2'h0);
      pick(4'hc, 2'h2, 4'h3, 2'h2);
      drain();
      summarize();
   end
endmodule : tb_top

// ### tqs_defs.svh
// Constants of the transmit queue scheduling and discard routing block
// Contract
// - Queue port field selects output port 0-3
// - Priority 0 lowest, 3 highest, read-only
// - Queue priority comes from packet DMA
// - CRF queue wins ties at equal priority
// - Length mismatch goes to its discard queue
// - Segment timeout goes to its discard queue
// - Retries above limit go to discard queue
// - Error response goes to its discard queue
// - Failed segment gives error completion code; block gives it only when multiseg is also set
// - Block writes status and pushes descriptor itself
// - Programming error goes to its discard queue
// - Type 11 length/16 above ssize is discarded
`ifndef TQS_DEFS_SVH
`define TQS_DEFS_SVH
// ==========================================================
// Widths
`define TQS_NQ 16
`define TQS_QW 4
`define TQS_QPR 4
`define TQS_DW 32
`define TQS_BW 8
`define TQS_AW 8
`define TQS_IW 6
`define TQS_QID_W 14
`define TQS_LEN_W 16
`define TQS_SSZ_W 12
`define TQS_SEG_SHIFT 4
`define TQS_RTY_W 8
`define TQS_CC_W 4
`define TQS_NEV 6
// ==========================================================
// Register word indices (byte address = index * 4)
`define TQS_IDX_INFO0 6'h00
`define TQS_IDX_INFO1 6'h01
`define TQS_IDX_INFO2 6'h02
`define TQS_IDX_INFO3 6'h03
`define TQS_IDX_DQ0 6'h04
`define TQS_IDX_DQ1 6'h05
`define TQS_IDX_DQ2 6'h06
`define TQS_IDX_RETRY 6'h07
`define TQS_IDX_IST 6'h08
`define TQS_IDX_ICLR 6'h09
`define TQS_IDX_IEN 6'h0a
`define TQS_IDX_LO 2
// ==========================================================
// Field positions, masks, reset values, codes
`define TQS_F_PORT 5:4
`define TQS_F_VC 3
`define TQS_F_CRF 0
`define TQS_F_DQ_HI 29:16
`define TQS_F_DQ_LO 13:0
`define TQS_DQ_MASK 32'h3fff3fff
`define TQS_DQ_RST 32'h00000000
`define TQS_RTY_RST 8'h03
`define TQS_CC_OK 4'h0
`define TQS_CC_ERR 4'h1
`define TQS_RESP_OK 2'h0
`define TQS_RESP_ERR 2'h2
`define TQS_EV_LEN 0
`define TQS_EV_TOUT 1
`define TQS_EV_RETRY 2
`define TQS_EV_ERR 3
`define TQS_EV_PROG 4
`define TQS_EV_SSIZE 5
`endif

// ### tqs_far_model.sv
// Link-side ready model for the transmit and release streams
`timescale 1ns/1ps
module tqs_far_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pace select, high stalls at random
   input wire logic slow,
   // Streams from the block
   input wire logic tx_valid,
   output logic tx_ready = 1'b0,
   input wire logic rel_valid,
   output logic rel_ready = 1'b0
);
   int seed = 32'hd62bb5af;
   // Ready changes just after each edge, never in reset
   always @(posedge aclk) begin
      tx_ready <= aresetn && (!slow || $random(seed) % 2 == 0);
      rel_ready <= aresetn && (!slow || $random(seed) % 2 == 0);
   end
endmodule : tqs_far_model

// ### tqs_pkg.sv
// Types of the transmit queue scheduling and discard routing block
`include "tqs_defs.svh"
package tqs_pkg;
   typedef logic [`TQS_DW-1:0] tqs_word_t;
   typedef logic [`TQS_QID_W-1:0] tqs_qid_t;
   typedef logic [`TQS_SSZ_W-1:0] tqs_seg_t;
   // Descriptor offered by the packet DMA
   typedef struct packed {
      tqs_word_t ptr;
      logic [`TQS_QW-1:0] queue;
      logic type11;
      logic prog_err;
      logic [`TQS_LEN_W-1:0] msg_len;
      tqs_seg_t ssize;
   } tqs_desc_s;
   // Descriptor sent toward a link port
   typedef struct packed {
      tqs_word_t ptr;
      logic [1:0] port;
      logic [1:0] prio;
      logic crf;
   } tqs_tx_s;
   // Finished message reported by the link side
   typedef struct packed {
      tqs_word_t ptr;
      tqs_qid_t ret_qid;
      logic len_mis;
      logic tout;
      logic [`TQS_RTY_W-1:0] retry_cnt;
      logic err_resp;
      logic multiseg;
      logic seg_fail;
   } tqs_comp_s;
   // Released descriptor with queue and completion code
   typedef struct packed {
      tqs_word_t ptr;
      tqs_qid_t qid;
      logic [`TQS_CC_W-1:0] ccode;
   } tqs_rel_s;
   // Scheduler pick
   typedef struct packed {
      logic [`TQS_QW-1:0] queue;
      logic [1:0] port;
      logic [1:0] prio;
      logic crf;
   } tqs_sched_s;
endpackage : tqs_pkg

// ### tqs_sched_discard.sv
// Transmit queue scheduling and discard routing with AXI4-Lite registers
`timescale 1ns/1ps
`include "tqs_defs.svh"
module tqs_sched_discard #(
   parameter int NQ = `TQS_NQ
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [`TQS_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [`TQS_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [`TQS_AW-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [`TQS_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Packet DMA queue state
   input wire logic [NQ-1:0] dma_queue_req,
   input wire logic [NQ-1:0][1:0] dma_queue_prio,
   // Scheduler pick
   output logic sched_valid,
   input wire logic sched_ready,
   output tqs_pkg::tqs_sched_s sched,
   // Descriptor in from packet DMA
   input wire logic desc_valid,
   output logic desc_ready,
   input wire tqs_pkg::tqs_desc_s desc,
   // Descriptor out to link ports
   output logic tx_valid,
   input wire logic tx_ready,
   output tqs_pkg::tqs_tx_s tx,
   // Completion from link side
   input wire logic comp_valid,
   output logic comp_ready,
   input wire tqs_pkg::tqs_comp_s comp,
   // Released descriptor to queue manager
   output logic rel_valid,
   input wire logic rel_ready,
   output tqs_pkg::tqs_rel_s rel,
   // Interrupt
   output logic irq
);
   // ==========================================================
   // Register state
   logic [NQ-1:0][1:0] port_reg;
   logic [NQ-1:0] vc_reg;
   logic [NQ-1:0] crf_reg;
   logic [NQ*`TQS_BW-1:0] info_flat;
   tqs_pkg::tqs_word_t dq_reg [3];
   logic [`TQS_RTY_W-1:0] retry_lim_reg;
   logic [`TQS_NEV-1:0] ist_reg;
   logic [`TQS_NEV-1:0] ien_reg;
   logic [`TQS_NEV-1:0] ev;
   logic [`TQS_DW-1:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [1:0] bresp_reg;
   logic bvalid_reg;
   logic rvalid_reg;
   logic wr_go;
   logic wr_ok;
   logic rd_ok;
   logic [`TQS_IW-1:0] wr_idx;
   logic [`TQS_IW-1:0] rd_idx;
   logic [`TQS_DW-1:0] rd_data;
   tqs_pkg::tqs_qid_t dq_len, dq_tout, dq_retry, dq_err, dq_prog, dq_ssize;
   // Byte-lane merge of a write into a stored word
   function automatic tqs_pkg::tqs_word_t merge(
      input tqs_pkg::tqs_word_t old_w,
      input tqs_pkg::tqs_word_t new_w,
      input logic [3:0] be);
      merge = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge[i*`TQS_BW +: `TQS_BW] = new_w[i*`TQS_BW +: `TQS_BW];
         end
      end
   endfunction : merge

   // ==========================================================
   // AXI4-Lite handshakes: address and data taken together
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = !rvalid_reg;
   assign wr_idx = s_axi_awaddr[`TQS_AW-1:`TQS_IDX_LO];
   assign rd_idx = s_axi_araddr[`TQS_AW-1:`TQS_IDX_LO];
   assign wr_ok = wr_idx <= `TQS_IDX_IEN;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `TQS_RESP_OK;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_ok ? `TQS_RESP_OK : `TQS_RESP_ERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Read data select; unmapped words read zero with an error
   always_comb begin
      rd_data = '0;
      rd_ok = 1'b1;
      case (rd_idx)
         `TQS_IDX_INFO0: rd_data = info_flat[0*`TQS_DW +: `TQS_DW];
         `TQS_IDX_INFO1: rd_data = info_flat[1*`TQS_DW +: `TQS_DW];
         `TQS_IDX_INFO2: rd_data = info_flat[2*`TQS_DW +: `TQS_DW];
         `TQS_IDX_INFO3: rd_data = info_flat[3*`TQS_DW +: `TQS_DW];
         `TQS_IDX_DQ0: rd_data = dq_reg[0];
         `TQS_IDX_DQ1: rd_data = dq_reg[1];
         `TQS_IDX_DQ2: rd_data = dq_reg[2];
         `TQS_IDX_RETRY: rd_data = tqs_pkg::tqs_word_t'(retry_lim_reg);
         `TQS_IDX_IST: rd_data = tqs_pkg::tqs_word_t'(ist_reg);
         `TQS_IDX_ICLR: rd_data = '0;
         `TQS_IDX_IEN: rd_data = tqs_pkg::tqs_word_t'(ien_reg);
         default: rd_ok = 1'b0;
      endcase
   end
   // Read response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= `TQS_RESP_OK;
      end else if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_data;
         rresp_reg <= rd_ok ? `TQS_RESP_OK : `TQS_RESP_ERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Per-queue schedule byte, four to a word
   for (genvar q = 0; q < NQ; q++) begin : g_q
      localparam int R = q / `TQS_QPR;
      localparam int B = q % `TQS_QPR;
      logic [`TQS_BW-1:0] wb;
      assign wb = s_axi_wdata[B*`TQS_BW +: `TQS_BW];
      // Priority bits mirror the packet DMA, reserved bits zero
      assign info_flat[q*`TQS_BW +: `TQS_BW] = {2'h0, port_reg[q],
         vc_reg[q], dma_queue_prio[q], crf_reg[q]};
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            port_reg[q] <= 2'h0;
            vc_reg[q] <= 1'b0;
            crf_reg[q] <= 1'b0;
         end else if (wr_go && s_axi_wstrb[B] &&
                      wr_idx == `TQS_IDX_INFO0 + R) begin
            port_reg[q] <= wb[`TQS_F_PORT];
            vc_reg[q] <= wb[`TQS_F_VC];
            crf_reg[q] <= wb[`TQS_F_CRF];
         end
      end
   end
   // Discard queue ids, retry limit, interrupt enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dq_reg[0] <= `TQS_DQ_RST;
         dq_reg[1] <= `TQS_DQ_RST;
         dq_reg[2] <= `TQS_DQ_RST;
         retry_lim_reg <= `TQS_RTY_RST;
         ien_reg <= '0;
      end else if (wr_go) begin
         case (wr_idx)
            `TQS_IDX_DQ0: dq_reg[0] <= merge(dq_reg[0], s_axi_wdata,
               s_axi_wstrb) & `TQS_DQ_MASK;
            `TQS_IDX_DQ1: dq_reg[1] <= merge(dq_reg[1], s_axi_wdata,
               s_axi_wstrb) & `TQS_DQ_MASK;
            `TQS_IDX_DQ2: dq_reg[2] <= merge(dq_reg[2], s_axi_wdata,
               s_axi_wstrb) & `TQS_DQ_MASK;
            `TQS_IDX_RETRY: begin
               if (s_axi_wstrb[0]) begin
                  retry_lim_reg <= s_axi_wdata[`TQS_RTY_W-1:0];
               end
            end
            `TQS_IDX_IEN: begin
               if (s_axi_wstrb[0]) begin
                  ien_reg <= s_axi_wdata[`TQS_NEV-1:0];
               end
            end
            default: ;
         endcase
      end
   end

   assign dq_len = dq_reg[0][`TQS_F_DQ_HI];
   assign dq_tout = dq_reg[0][`TQS_F_DQ_LO];
   assign dq_retry = dq_reg[1][`TQS_F_DQ_HI];
   assign dq_err = dq_reg[1][`TQS_F_DQ_LO];
   assign dq_prog = dq_reg[2][`TQS_F_DQ_HI];
   assign dq_ssize = dq_reg[2][`TQS_F_DQ_LO];
   // Sticky status: a set in the clearing cycle survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ist_reg <= '0;
      end else if (wr_go && wr_idx == `TQS_IDX_ICLR && s_axi_wstrb[0]) begin
         ist_reg <= (ist_reg & ~s_axi_wdata[`TQS_NEV-1:0]) | ev;
      end else begin
         ist_reg <= ist_reg | ev;
      end
   end
   assign irq = |(ist_reg & ien_reg);
   // ==========================================================
   // Scheduler: highest priority, then CRF, then lowest queue
   logic best_ok;
   logic [`TQS_QW-1:0] best_q;
   logic [2:0] best_key;
   tqs_pkg::tqs_sched_s sched_reg;
   logic sched_valid_reg;
   always_comb begin
      best_ok = 1'b0;
      best_q = '0;
      best_key = '0;
      for (int q = 0; q < NQ; q++) begin
         if (dma_queue_req[q] &&
             (!best_ok || {dma_queue_prio[q], crf_reg[q]} > best_key)) begin
            best_ok = 1'b1;
            best_q = q[`TQS_QW-1:0];
            best_key = {dma_queue_prio[q], crf_reg[q]};
         end
      end
   end

   // Pick is held until taken; VC bit plays no part
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sched_valid_reg <= 1'b0;
         sched_reg <= '0;
      end else if (!sched_valid_reg || sched_ready) begin
         sched_valid_reg <= best_ok;
         sched_reg.queue <= best_q;
         sched_reg.port <= port_reg[best_q];
         sched_reg.prio <= dma_queue_prio[best_q];
         sched_reg.crf <= crf_reg[best_q];
      end
   end
   assign sched_valid = sched_valid_reg;
   assign sched = sched_reg;
   // ==========================================================
   // Descriptor check and transmit path
   tqs_pkg::tqs_seg_t seg_cnt;
   logic bad_ssize;
   logic desc_bad;
   logic [1:0] sel_port;
   logic [1:0] sel_prio;
   logic tx_valid_reg;
   tqs_pkg::tqs_tx_s tx_reg;
   logic rel_valid_reg;
   tqs_pkg::tqs_rel_s rel_reg;
   tqs_pkg::tqs_rel_s rel_next;
   logic rel_free;
   logic tx_free;
   logic take_comp;
   logic take_bad;
   logic take_good;
   logic comp_fail;
   assign seg_cnt = tqs_pkg::tqs_seg_t'(desc.msg_len >> `TQS_SEG_SHIFT);
   assign bad_ssize = desc.type11 && (seg_cnt > desc.ssize);
   assign desc_bad = desc.prog_err || bad_ssize;
   assign sel_port = port_reg[desc.queue];
   assign sel_prio = dma_queue_prio[desc.queue];
   assign rel_free = !rel_valid_reg || rel_ready;
   assign tx_free = !tx_valid_reg || tx_ready;
   assign take_comp = comp_valid && rel_free;
   assign take_bad = desc_valid && desc_bad && rel_free && !comp_valid;
   assign take_good = desc_valid && !desc_bad && tx_free;
   assign comp_ready = rel_free;
   assign desc_ready = desc_bad ? (rel_free && !comp_valid) : tx_free;
   // Good descriptor goes out on its queue's port
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_valid_reg <= 1'b0;
         tx_reg <= '0;
      end else if (take_good) begin
         tx_valid_reg <= 1'b1;
         tx_reg.ptr <= desc.ptr;
         tx_reg.port <= sel_port;
         tx_reg.prio <= sel_prio;
         tx_reg.crf <= crf_reg[desc.queue];
      end else if (tx_ready) begin
         tx_valid_reg <= 1'b0;
      end
   end
   assign tx_valid = tx_valid_reg;
   assign tx = tx_reg;
   // ==========================================================
   // Release routing: completions first, then rejected descriptors
   assign comp_fail = comp.len_mis || comp.tout || comp.err_resp ||
      (comp.retry_cnt > retry_lim_reg) || (comp.multiseg && comp.seg_fail);

   always_comb begin
      rel_next = '0;
      ev = '0;
      if (take_comp) begin
         rel_next.ptr = comp.ptr;
         rel_next.qid = comp.ret_qid;
         rel_next.ccode = comp_fail ? `TQS_CC_ERR : `TQS_CC_OK;
         if (comp.len_mis) begin
            rel_next.qid = dq_len;
            ev[`TQS_EV_LEN] = 1'b1;
         end else if (comp.tout) begin
            rel_next.qid = dq_tout;
            ev[`TQS_EV_TOUT] = 1'b1;
         end else if (comp.retry_cnt > retry_lim_reg) begin
            rel_next.qid = dq_retry;
            ev[`TQS_EV_RETRY] = 1'b1;
         end else if (comp.err_resp) begin
            rel_next.qid = dq_err;
            ev[`TQS_EV_ERR] = 1'b1;
         end
      end else if (take_bad) begin
         rel_next.ptr = desc.ptr;
         rel_next.ccode = `TQS_CC_ERR;
         if (desc.prog_err) begin
            rel_next.qid = dq_prog;
            ev[`TQS_EV_PROG] = 1'b1;
         end else begin
            rel_next.qid = dq_ssize;
            ev[`TQS_EV_SSIZE] = 1'b1;
         end
      end
   end

   // The block itself pushes the released descriptor
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rel_valid_reg <= 1'b0;
         rel_reg <= '0;
      end else if (take_comp || take_bad) begin
         rel_valid_reg <= 1'b1;
         rel_reg <= rel_next;
      end else if (rel_ready) begin
         rel_valid_reg <= 1'b0;
      end
   end

   assign rel_valid = rel_valid_reg;
   assign rel = rel_reg;

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_write_resp_next: assert property (wr_go |=> s_axi_bvalid &&
      s_axi_bresp == ($past(wr_ok) ? `TQS_RESP_OK : `TQS_RESP_ERR))
      else $error("write response missing or wrong");
   a_port_follows_cfg: assert property (take_good |=> tx_valid &&
      tx.port == $past(sel_port))
      else $error("tx port does not match queue config");
   a_prio_from_dma: assert property (take_good |=>
      tx.prio == $past(sel_prio))
      else $error("tx priority not from packet dma");
   a_len_mismatch_q: assert property (take_comp && comp.len_mis |=>
      rel_valid && rel.qid == $past(dq_len))
      else $error("length mismatch not routed");
   a_timeout_q_route: assert property (take_comp && !comp.len_mis &&
      comp.tout |=> rel.qid == $past(dq_tout) && rel.ccode == `TQS_CC_ERR)
      else $error("timeout not routed");
   a_retry_q_route: assert property (take_comp && !comp.len_mis &&
      !comp.tout && comp.retry_cnt > retry_lim_reg |=>
      rel.qid == $past(dq_retry))
      else $error("excess retry not routed");
   a_seg_fail_code: assert property (take_comp && comp.multiseg &&
      comp.seg_fail |=> rel_valid && rel.ccode == `TQS_CC_ERR)
      else $error("segment failure not flagged");
   a_prog_err_route: assert property (take_bad && desc.prog_err |=>
      rel_valid && rel.qid == $past(dq_prog) && rel.ccode == `TQS_CC_ERR)
      else $error("programming error not routed");
   a_ssize_discard: assert property (desc_valid && desc_ready &&
      bad_ssize && !desc.prog_err |=> rel_valid &&
      rel.qid == $past(dq_ssize) && ist_reg[`TQS_EV_SSIZE])
      else $error("segment size violation not discarded");
   a_irq_from_status: assert property (ev[`TQS_EV_ERR] && ien_reg[`TQS_EV_ERR]
      |=> irq)
      else $error("enabled event did not raise irq");
endmodule : tqs_sched_discard
